// file: rtl/uart_line_format_and_status.sv
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module uart_line_format_and_status
  import uart_fmt_pkg::*;
(
  input wire logic clk, // 20 MHz clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire bus_req_t bus, // register port request
  output logic [7:0] rdata, // read data, valid the cycle after a read
  input wire logic rxd, // serial receive input
  output logic txd, // serial transmit output
  output logic ls_irq, // receiver line status interrupt request
  output logic tx_irq // hold empty interrupt request
);

  // ************************************************************
  // Register port
  // ************************************************************
  lfc_t lfc_r, lfc_nxt;
  logic [3:0] ier_r, ier_nxt;
  logic [15:0] div_r, div_nxt;
  logic fifo_en_r, fifo_en_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rd_data, wr_data, rd_lsr, div_wr, rx_clr, tx_clr;
  logic [7:0] line_status;
  rx_entry_t rx_head;

  always_comb begin
    lfc_nxt = lfc_r;
    ier_nxt = ier_r;
    div_nxt = div_r;
    fifo_en_nxt = fifo_en_r;
    rdata_nxt = 8'h00;
    rx_clr = 1'b0;
    tx_clr = 1'b0;
    div_wr = 1'b0;
    rd_data = bus.rd && bus.addr == ADDR_DATA && !lfc_r.divisor_latch_select;
    wr_data = bus.wr && bus.addr == ADDR_DATA && !lfc_r.divisor_latch_select;
    rd_lsr = bus.rd && bus.addr == ADDR_LSR;
    if (bus.wr) begin
      unique case (bus.addr)
        ADDR_LFC: lfc_nxt = lfc_t'(bus.wdata);
        ADDR_DATA: begin
          if (lfc_r.divisor_latch_select) begin
            div_nxt[7:0] = bus.wdata;
            div_wr = 1'b1;
          end
        end
        ADDR_IER: begin
          if (lfc_r.divisor_latch_select) begin
            div_nxt[15:8] = bus.wdata;
            div_wr = 1'b1;
          end else begin
            ier_nxt = bus.wdata[3:0];
          end
        end
        ADDR_FIFO_CTRL: begin
          fifo_en_nxt = bus.wdata[FCTL_EN];
          rx_clr = bus.wdata[FCTL_RX_CLR] || (bus.wdata[FCTL_EN] != fifo_en_r);
          tx_clr = bus.wdata[FCTL_TX_CLR] || (bus.wdata[FCTL_EN] != fifo_en_r);
        end
        default: ;
      endcase
    end
    if (bus.rd) begin
      unique case (bus.addr)
        ADDR_DATA: rdata_nxt = lfc_r.divisor_latch_select ? div_r[7:0] : rx_head.data;
        ADDR_IER: rdata_nxt = lfc_r.divisor_latch_select ? div_r[15:8] : {4'h0, ier_r};
        ADDR_FIFO_CTRL: rdata_nxt = {7'h00, fifo_en_r};
        ADDR_LFC: rdata_nxt = lfc_r;
        ADDR_LSR: rdata_nxt = line_status;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfc_r <= lfc_t'(LFC_RESET);
      ier_r <= IER_RESET;
      div_r <= DIV_RESET;
      fifo_en_r <= 1'b0;
      rdata_r <= 8'h00;
    end else if (ce) begin
      lfc_r <= lfc_nxt;
      ier_r <= ier_nxt;
      div_r <= div_nxt;
      fifo_en_r <= fifo_en_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

  // ************************************************************
  // Baud tick at sixteen times the bit rate
  // ************************************************************
  logic [15:0] bcnt_r, bcnt_nxt;
  logic tick;

  always_comb begin
    tick = (bcnt_r <= DIV_ONE);
    bcnt_nxt = tick ? div_r : bcnt_r - DIV_ONE;
    if (div_wr) begin
      bcnt_nxt = div_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bcnt_r <= DIV_RESET;
    end else if (ce) begin
      bcnt_r <= bcnt_nxt;
    end
  end

  // Parity bit for the configured format, shared by both directions.
  function automatic logic par_bit(input logic [7:0] d, input lfc_t f);
    logic [7:0] mask;
    mask = 8'hFF >> (2'h3 - f.word_len);
    if (f.stick_parity) begin
      par_bit = !f.even_parity;
    end else begin
      par_bit = (^(d & mask)) ^ !f.even_parity;
    end
  endfunction

  logic [2:0] last_bit;
  assign last_bit = 3'h4 + {1'b0, lfc_r.word_len};

  // ************************************************************
  // Transmit holding buffer and shifter
  // ************************************************************
  logic [7:0] txm [FIFO_DEPTH];
  logic [PTR_W-1:0] tx_wp_r, tx_wp_nxt, tx_rp_r, tx_rp_nxt;
  logic [CNT_W-1:0] tx_cnt_r, tx_cnt_nxt;
  logic tx_push, tx_pop;
  tx_state_t tx_st_r, tx_st_nxt;
  logic [4:0] tx_tk_r, tx_tk_nxt;
  logic [2:0] tx_bit_r, tx_bit_nxt;
  logic [7:0] tx_sh_r, tx_sh_nxt;
  logic tx_par_r, tx_par_nxt;
  logic txd_r, txd_nxt;
  logic [4:0] stop_last;
  logic line;

  always_comb begin
    tx_push = wr_data && tx_cnt_r != (fifo_en_r ? FIFO_CAP : HOLD_CAP);
    tx_pop = 1'b0;
    tx_st_nxt = tx_st_r;
    tx_tk_nxt = tx_tk_r;
    tx_bit_nxt = tx_bit_r;
    tx_sh_nxt = tx_sh_r;
    tx_par_nxt = tx_par_r;
    if (!lfc_r.stop_sel) begin
      stop_last = STOP_ONE;
    end else begin
      stop_last = (lfc_r.word_len == 2'h0) ? STOP_ONE_HALF : STOP_TWO;
    end
    unique case (tx_st_r)
      TX_IDLE: begin
        if (tx_cnt_r != '0) begin
          tx_pop = 1'b1;
          tx_sh_nxt = txm[tx_rp_r];
          tx_par_nxt = par_bit(txm[tx_rp_r], lfc_r);
          tx_tk_nxt = 5'h00;
          tx_st_nxt = TX_START;
        end
      end
      TX_START: begin
        if (tick) begin
          tx_tk_nxt = tx_tk_r + 5'h01;
          if (tx_tk_r[3:0] == TICK_LAST) begin
            tx_tk_nxt = 5'h00;
            tx_bit_nxt = 3'h0;
            tx_st_nxt = TX_DATA;
          end
        end
      end
      TX_DATA: begin
        if (tick) begin
          tx_tk_nxt = tx_tk_r + 5'h01;
          if (tx_tk_r[3:0] == TICK_LAST) begin
            tx_tk_nxt = 5'h00;
            tx_sh_nxt = tx_sh_r >> 1;
            tx_bit_nxt = tx_bit_r + 3'h1;
            if (tx_bit_r == last_bit) begin
              tx_st_nxt = lfc_r.parity_en ? TX_PAR : TX_STOP;
            end
          end
        end
      end
      TX_PAR: begin
        if (tick) begin
          tx_tk_nxt = tx_tk_r + 5'h01;
          if (tx_tk_r[3:0] == TICK_LAST) begin
            tx_tk_nxt = 5'h00;
            tx_st_nxt = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (tick) begin
          tx_tk_nxt = tx_tk_r + 5'h01;
          if (tx_tk_r == stop_last) begin
            tx_st_nxt = TX_IDLE;
          end
        end
      end
    endcase
    unique case (tx_st_r)
      TX_START: line = 1'b0;
      TX_DATA: line = tx_sh_r[0];
      TX_PAR: line = tx_par_r;
      default: line = 1'b1;
    endcase
    // Break only masks the pin; the shifter keeps running underneath.
    txd_nxt = line && !lfc_r.break_ctrl;
    tx_wp_nxt = tx_wp_r + PTR_W'(tx_push);
    tx_rp_nxt = tx_rp_r + PTR_W'(tx_pop);
    tx_cnt_nxt = tx_cnt_r + CNT_W'(tx_push) - CNT_W'(tx_pop);
    if (tx_clr) begin
      tx_wp_nxt = '0;
      tx_rp_nxt = '0;
      tx_cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && tx_push) begin
      txm[tx_wp_r] <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      tx_cnt_r <= '0;
      tx_st_r <= TX_IDLE;
      tx_tk_r <= 5'h00;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 8'h00;
      tx_par_r <= 1'b0;
      txd_r <= 1'b1;
    end else if (ce) begin
      tx_wp_r <= tx_wp_nxt;
      tx_rp_r <= tx_rp_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_st_r <= tx_st_nxt;
      tx_tk_r <= tx_tk_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_par_r <= tx_par_nxt;
      txd_r <= txd_nxt;
    end
  end

  assign txd = txd_r;

  // ************************************************************
  // Receiver
  // ************************************************************
  rx_state_t rx_st_r, rx_st_nxt;
  logic [3:0] rx_tk_r, rx_tk_nxt;
  logic [2:0] rx_bit_r, rx_bit_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt;
  logic rx_pbit_r, rx_pbit_nxt;
  logic rx_zero_r, rx_zero_nxt;
  logic [1:0] rx_hi_r, rx_hi_nxt;
  logic rx_done;
  rx_entry_t rx_new;
  logic [7:0] rx_char;

  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_tk_nxt = rx_tk_r;
    rx_bit_nxt = rx_bit_r;
    rx_sh_nxt = rx_sh_r;
    rx_pbit_nxt = rx_pbit_r;
    rx_zero_nxt = rx_zero_r;
    rx_hi_nxt = rx_hi_r;
    rx_done = 1'b0;
    rx_char = rx_sh_r >> (2'h3 - lfc_r.word_len);
    rx_new = '0;
    if (tick) begin
      rx_tk_nxt = rx_tk_r + 4'h1;
      unique case (rx_st_r)
        RX_IDLE: begin
          rx_tk_nxt = 4'h0;
          if (!rxd) begin
            rx_st_nxt = RX_START;
          end
        end
        RX_START: begin
          // Two looks at the start bit reject glitches and confirm resync.
          if ((rx_tk_r == TICK_MID || rx_tk_r == TICK_MID2) && rxd) begin
            rx_st_nxt = RX_IDLE;
          end else if (rx_tk_r == TICK_LAST) begin
            rx_st_nxt = RX_DATA;
            rx_bit_nxt = 3'h0;
            rx_sh_nxt = 8'h00;
            rx_zero_nxt = 1'b1;
          end
        end
        RX_DATA: begin
          if (rx_tk_r == TICK_MID) begin
            rx_sh_nxt = {rxd, rx_sh_r[7:1]};
            rx_zero_nxt = rx_zero_r && !rxd;
          end else if (rx_tk_r == TICK_LAST) begin
            rx_bit_nxt = rx_bit_r + 3'h1;
            if (rx_bit_r == last_bit) begin
              rx_st_nxt = lfc_r.parity_en ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_tk_r == TICK_MID) begin
            rx_pbit_nxt = rxd;
            rx_zero_nxt = rx_zero_r && !rxd;
          end else if (rx_tk_r == TICK_LAST) begin
            rx_st_nxt = RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_tk_r == TICK_MID) begin
            rx_done = 1'b1;
            rx_new.fe = !rxd;
            rx_new.pe = lfc_r.parity_en && (rx_pbit_r != par_bit(rx_char, lfc_r));
            rx_new.bi = rx_zero_r && !rxd;
            rx_new.data = rx_new.bi ? 8'h00 : rx_char;
            rx_tk_nxt = 4'h0;
            rx_hi_nxt = 2'h0;
            if (rx_new.bi) begin
              rx_st_nxt = RX_BRK;
            end else if (!rxd) begin
              // The stop sample was the first look at this start bit, so resume at its middle.
              rx_st_nxt = RX_START;
              rx_tk_nxt = TICK_MID2;
            end else begin
              rx_st_nxt = RX_IDLE;
            end
          end
        end
        RX_BRK: begin
          rx_hi_nxt = rxd ? rx_hi_r + 2'h1 : 2'h0;
          if (rxd && rx_hi_r == BRK_MARK_SAMPLES - 2'h1) begin
            rx_st_nxt = RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r <= RX_IDLE;
      rx_tk_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_pbit_r <= 1'b0;
      rx_zero_r <= 1'b0;
      rx_hi_r <= 2'h0;
    end else if (ce) begin
      rx_st_r <= rx_st_nxt;
      rx_tk_r <= rx_tk_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_pbit_r <= rx_pbit_nxt;
      rx_zero_r <= rx_zero_nxt;
      rx_hi_r <= rx_hi_nxt;
    end
  end

  // ************************************************************
  // Receive buffer and line status
  // ************************************************************
  rx_entry_t rxm [FIFO_DEPTH];
  logic [PTR_W-1:0] rx_wp_r, rx_wp_nxt, rx_rp_r, rx_rp_nxt, rx_wa;
  logic [CNT_W-1:0] rx_cnt_r, rx_cnt_nxt, err_cnt_r, err_cnt_nxt;
  logic rx_push, rx_pop, rx_over, rx_full, rx_we;
  logic head_seen_r, head_seen_nxt;
  logic oe_r, oe_nxt, pe_r, pe_nxt, fe_r, fe_nxt, bi_r, bi_nxt, err7_r, err7_nxt;
  logic ls_irq_r, ls_irq_nxt, tx_irq_r, tx_irq_nxt;
  logic new_err, head_err, tx_hold_empty, tx_all_empty;

  assign rx_head = rxm[rx_rp_r];

  always_comb begin
    rx_pop = rd_data && rx_cnt_r != '0;
    rx_full = rx_cnt_r == (fifo_en_r ? FIFO_CAP : HOLD_CAP) && !rx_pop;
    rx_push = rx_done && !rx_full;
    // A single holding register is overwritten; a full fifo drops the newcomer.
    rx_over = rx_done && rx_full && !fifo_en_r;
    rx_we = rx_push || rx_over;
    rx_wa = rx_over ? rx_rp_r : rx_wp_r;
    new_err = rx_new.pe || rx_new.fe || rx_new.bi;
    head_err = rx_cnt_r != '0 && (rx_head.pe || rx_head.fe || rx_head.bi);
    rx_wp_nxt = rx_wp_r + PTR_W'(rx_push);
    rx_rp_nxt = rx_rp_r + PTR_W'(rx_pop);
    rx_cnt_nxt = rx_cnt_r + CNT_W'(rx_push) - CNT_W'(rx_pop);
    err_cnt_nxt = err_cnt_r + CNT_W'(rx_we && new_err) - CNT_W'((rx_pop || rx_over) && head_err);
    // Error flags of the head entry are folded in once, when it arrives at the head.
    head_seen_nxt = head_seen_r || rx_cnt_r != '0;
    oe_nxt = (oe_r && !rd_lsr) || (rx_done && rx_full);
    pe_nxt = (pe_r && !rd_lsr) || (!head_seen_r && head_err && rx_head.pe);
    fe_nxt = (fe_r && !rd_lsr) || (!head_seen_r && head_err && rx_head.fe);
    bi_nxt = (bi_r && !rd_lsr) || (!head_seen_r && head_err && rx_head.bi);
    if (rx_pop || rx_over) begin
      head_seen_nxt = 1'b0;
    end
    if (rx_clr) begin
      rx_wp_nxt = '0;
      rx_rp_nxt = '0;
      rx_cnt_nxt = '0;
      err_cnt_nxt = '0;
      head_seen_nxt = 1'b0;
    end
    err7_nxt = fifo_en_r && ((err7_r && !rd_lsr) || err_cnt_r != '0);
    tx_hold_empty = tx_cnt_r == '0;
    tx_all_empty = tx_hold_empty && tx_st_r == TX_IDLE;
    line_status = {err7_r && fifo_en_r, tx_all_empty, tx_hold_empty, bi_r, fe_r, pe_r, oe_r, rx_cnt_r != '0};
    ls_irq_nxt = ier_r[IER_LS] && (oe_nxt || pe_nxt || fe_nxt || bi_nxt);
    tx_irq_nxt = ier_r[IER_TX] && tx_cnt_nxt == '0;
  end

  always_ff @(posedge clk) begin
    if (ce && rx_we) begin
      rxm[rx_wa] <= rx_new;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_cnt_r <= '0;
      err_cnt_r <= '0;
      head_seen_r <= 1'b0;
      oe_r <= 1'b0;
      pe_r <= 1'b0;
      fe_r <= 1'b0;
      bi_r <= 1'b0;
      err7_r <= 1'b0;
      ls_irq_r <= 1'b0;
      tx_irq_r <= 1'b0;
    end else if (ce) begin
      rx_wp_r <= rx_wp_nxt;
      rx_rp_r <= rx_rp_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      err_cnt_r <= err_cnt_nxt;
      head_seen_r <= head_seen_nxt;
      oe_r <= oe_nxt;
      pe_r <= pe_nxt;
      fe_r <= fe_nxt;
      bi_r <= bi_nxt;
      err7_r <= err7_nxt;
      ls_irq_r <= ls_irq_nxt;
      tx_irq_r <= tx_irq_nxt;
    end
  end

  assign ls_irq = ls_irq_r;
  assign tx_irq = tx_irq_r;

endmodule // uart_line_format_and_status

`default_nettype wire

// file: rtl/uart_fmt_pkg.sv
package uart_fmt_pkg;

  // ************************************************************
  // Register map on the plain register port
  // ************************************************************
  localparam int unsigned ADDR_W = 3;
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_FIFO_CTRL = 3'h2;
  localparam logic [2:0] ADDR_LFC = 3'h3;
  localparam logic [2:0] ADDR_LSR = 3'h5;

  localparam logic [7:0] LFC_RESET = 8'h00;
  localparam logic [3:0] IER_RESET = 4'h0;
  localparam logic [15:0] DIV_RESET = 16'h0001;
  localparam logic [15:0] DIV_ONE = 16'h0001;

  // Fifo control fields.
  localparam int unsigned FCTL_EN = 0;
  localparam int unsigned FCTL_RX_CLR = 1;
  localparam int unsigned FCTL_TX_CLR = 2;

  // Interrupt enable fields.
  localparam int unsigned IER_RX = 0;
  localparam int unsigned IER_TX = 1;
  localparam int unsigned IER_LS = 2;

  // ************************************************************
  // Buffers and bit timing
  // ************************************************************
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned PTR_W = 4;
  localparam int unsigned CNT_W = 5;
  localparam logic [4:0] FIFO_CAP = 5'h10;
  localparam logic [4:0] HOLD_CAP = 5'h01;

  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] TICK_MID2 = 4'h8;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [4:0] STOP_ONE = 5'h0F;
  localparam logic [4:0] STOP_ONE_HALF = 5'h17;
  localparam logic [4:0] STOP_TWO = 5'h1F;
  localparam logic [1:0] BRK_MARK_SAMPLES = 2'h2;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic divisor_latch_select;
    logic break_ctrl;
    logic stick_parity;
    logic even_parity;
    logic parity_en;
    logic stop_sel;
    logic [1:0] word_len;
  } lfc_t;

  typedef struct packed {
    logic bi;
    logic fe;
    logic pe;
    logic [7:0] data;
  } rx_entry_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} rx_state_t;

endpackage

// file: verification/uart_line_format_and_status_properties.sv
`timescale 1ns/100ps
`default_nettype none

module line_status_checker
  import uart_fmt_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic ce, // clock enable
  input wire bus_req_t bus, // register request
  input wire logic [7:0] rdata, // read data
  input wire logic rxd, // serial input
  input wire logic txd, // serial output
  input wire logic ls_irq, // line status request
  input wire logic tx_irq // hold empty request
);
  logic [7:0] lfc_r, lfc_nxt;
  logic [3:0] ier_r, ier_nxt;
  logic fifo_r, fifo_nxt, brk_r, brk_nxt, lsr_rd, lfc_rd;
  logic [9:0] low_r, low_nxt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  assign lsr_rd = ce && bus.rd && bus.addr == ADDR_LSR;
  assign lfc_rd = ce && bus.rd && bus.addr == ADDR_LFC;

  always_comb begin
    lfc_nxt = lfc_r;
    ier_nxt = ier_r;
    fifo_nxt = fifo_r;
    if (ce && bus.wr && bus.addr == ADDR_LFC) lfc_nxt = bus.wdata;
    if (ce && bus.wr && bus.addr == ADDR_IER && !lfc_r[7]) ier_nxt = bus.wdata[3:0];
    if (ce && bus.wr && bus.addr == ADDR_FIFO_CTRL) fifo_nxt = bus.wdata[FCTL_EN];
    low_nxt = txd ? 10'h000 : low_r + 10'h001;
    brk_nxt = lfc_r[6] | (!txd & brk_r);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfc_r <= LFC_RESET;
      ier_r <= IER_RESET;
      fifo_r <= 1'b0;
      brk_r <= 1'b0;
      low_r <= 10'h000;
    end else begin
      lfc_r <= lfc_nxt;
      ier_r <= ier_nxt;
      fifo_r <= fifo_nxt;
      brk_r <= brk_nxt;
      low_r <= low_nxt;
    end
  end

  a_format_readback: assert property ($past(lfc_rd) |-> rdata == $past(lfc_r))
    else $error("format read back differs from last write");
  a_break_drives_low: assert property (lfc_r[6] && $past(lfc_r[6]) |=> !txd)
    else $error("serial output not low during break");
  // Low runs are whole bits only with a divisor of one, sixteen cycles per bit.
  a_start_bit_whole: assert property ($rose(txd) && !brk_r |-> low_r[3:0] == 4'h0)
    else $error("serial low run not a whole number of bits");
  a_summary_zero: assert property ($past(lsr_rd && !fifo_r) |-> !rdata[7])
    else $error("error summary set outside fifo mode");
  a_all_empty_hold: assert property ($past(lsr_rd) && rdata[6] |-> rdata[5])
    else $error("all empty without hold empty");
  a_empty_line_idle: assert property ($past(lsr_rd) && rdata[6] && !lfc_r[6] &&
    !$past(lfc_r[6], 2) |-> txd)
    else $error("transmitter empty but line not idle");
  a_line_irq_gated: assert property (ls_irq |-> ier_r[IER_LS] || $past(ier_r[IER_LS]))
    else $error("line status request while disabled");
  a_hold_irq_gated: assert property (tx_irq |-> ier_r[IER_TX] || $past(ier_r[IER_TX]))
    else $error("hold empty request while disabled");

  c_overrun: cover property ($past(lsr_rd) && rdata[1]);
  c_framing: cover property ($past(lsr_rd) && rdata[3]);
  c_break: cover property ($past(lsr_rd) && rdata[4]);
endmodule // line_status_checker

bind uart_line_format_and_status line_status_checker chk_i (.clk(clk), .rst_n(rst_n), .ce(ce),
  .bus(bus), .rdata(rdata), .rxd(rxd), .txd(txd), .ls_irq(ls_irq), .tx_irq(tx_irq));

`default_nettype wire

// file: verification/uart_far_end.sv
`timescale 1ns/100ps
`default_nettype none

module uart_far_end (
  input wire logic clk, // bench clock
  input wire logic txd, // line from the block
  output var logic rxd // line into the block, idle high
);
  initial rxd = 1'b1;

  task automatic put_bit(input logic b);
    @(posedge clk);
    rxd <= b;
    repeat (15) @(posedge clk);
  endtask

  // One stop bit is always sent, so a longer setting is never leaned on.
  task automatic send(input logic [7:0] d, input int n, input int par, input logic stop,
    input logic start);
    if (start) put_bit(1'b0);
    for (int k = 0; k < n; k++)
      put_bit(d[k]);
    if (par >= 0) put_bit(par[0]);
    put_bit(stop);
  endtask

  // Samples each bit at its middle, then counts cycles to the next start edge.
  task automatic get_frame(input int nb, output logic [9:0] bits, output int gap);
    int c;
    c = 0;
    bits = '0;
    while (txd !== 1'b0 && c < 3000) begin
      @(negedge clk);
      c++;
    end
    repeat (8) @(negedge clk);
    for (int k = 0; k < nb; k++) begin
      repeat (16) @(negedge clk);
      bits[k] = txd;
    end
    c = 8 + 16 * nb;
    do begin
      @(negedge clk);
      c++;
    end while (txd !== 1'b1 && c < 1000);
    while (txd !== 1'b0 && c < 1000) begin
      @(negedge clk);
      c++;
    end
    gap = c;
  endtask
endmodule // uart_far_end

`default_nettype wire

// file: verification/uart_line_format_and_status_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module uart_line_format_and_status_tb_top
  import uart_fmt_pkg::*;
;
  typedef struct packed {
    logic [7:0] lfc;
    logic [7:0] d;
    logic [5:0] stop_t;
  } row_t;
  row_t rows [8] = '{'{8'h00, 8'hA5, 6'h10}, '{8'h04, 8'h3C, 6'h18}, '{8'h05, 8'h5A, 6'h20},
    '{8'h0A, 8'h6B, 6'h10}, '{8'h1B, 8'hC3, 6'h10}, '{8'h2B, 8'h81, 6'h10},
    '{8'h3B, 8'h7E, 6'h10}, '{8'h1F, 8'h96, 6'h20}};
  logic clk, rst_n, ce, rxd, txd, ls_irq, tx_irq;
  bus_req_t bus;
  logic [7:0] rdata, s;
  logic [9:0] fb;
  int bad_count, n_tests, gap, n, p;

  uart_line_format_and_status dut (.clk(clk), .rst_n(rst_n), .ce(ce), .bus(bus),
    .rdata(rdata), .rxd(rxd), .txd(txd), .ls_irq(ls_irq), .tx_irq(tx_irq));
  uart_far_end partner (.clk(clk), .txd(txd), .rxd(rxd));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [7:0] mask(logic [7:0] lfc);
    return 8'hFF >> (3 - lfc[1:0]);
  endfunction

  function automatic int par_of(logic [7:0] lfc, logic [7:0] d);
    if (!lfc[3]) return -1;
    if (lfc[5]) return lfc[4] ? 0 : 1;
    return lfc[4] ? int'(^(d & mask(lfc))) : int'(~^(d & mask(lfc)));
  endfunction

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g,
    input logic [9:0] m = 10'h3FF);
    n_tests++;
    if ((g & m) !== (e & m)) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // The second character may start up to three cycles late while it is loaded.
  task automatic chk_near(input string nm, input int e, input int g);
    n_tests++;
    if (g < e || g > e + 3) begin
      bad_count++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic rd_chk(input string nm, input logic [2:0] a, input logic [7:0] e,
    input logic [7:0] m = 8'hFF);
    rd(a, s);
    chk(nm, e, s, m);
  endtask

  task automatic wait_empty();
    for (int i = 0; i < 40; i++) begin
      rd(ADDR_LSR, s);
      if (s[6] === 1'b1) break;
      repeat (16) @(posedge clk);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    test_done();
  end

  initial begin
    bad_count = 0;
    n_tests = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    bus = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("status after reset", ADDR_LSR, 8'h60);
    rd_chk("format after reset", ADDR_LFC, LFC_RESET);
    foreach (rows[i]) begin
      n = 5 + rows[i].lfc[1:0];
      p = par_of(rows[i].lfc, rows[i].d);
      wr(ADDR_LFC, rows[i].lfc);
      fork
        partner.get_frame(n + (p >= 0 ? 1 : 0), fb, gap);
        begin
          wr(ADDR_DATA, rows[i].d);
          wr(ADDR_DATA, rows[i].d);
        end
      join
      chk("frame", 10'(rows[i].d & mask(rows[i].lfc)) | (10'(p > 0) << n), fb,
        (p >= 0) ? (10'h3FF >> (9 - n)) : (10'h3FF >> (10 - n)));
      chk_near("char spacing", 16 * (1 + n + (p >= 0 ? 1 : 0)) + rows[i].stop_t, gap);
      wait_empty();
      partner.send(rows[i].d, n, p, 1'b1, 1'b1);
      rd_chk("status after receive", ADDR_LSR, 8'h61);
      rd_chk("received data", ADDR_DATA, rows[i].d & mask(rows[i].lfc));
    end
    wr(ADDR_LFC, 8'h43);
    repeat (3) @(negedge clk);
    chk("line in break", 10'h000, txd);
    wr(ADDR_LFC, 8'h83);
    repeat (3) @(negedge clk);
    chk("line after break", 10'h001, txd);
    wr(ADDR_DATA, 8'h02);
    rd_chk("divisor low", ADDR_DATA, 8'h02);
    rd_chk("no send via divisor", ADDR_LSR, 8'h60);
    wr(ADDR_DATA, DIV_ONE[7:0]);
    wr(ADDR_LFC, 8'h03);
    wr(ADDR_LSR, 8'h00);
    rd_chk("status write ignored", ADDR_LSR, 8'h60);
    rd_chk("unmapped read", 3'h4, 8'h00);
    wr(ADDR_IER, 8'h06);
    partner.send(8'h11, 8, -1, 1'b1, 1'b1);
    partner.send(8'h22, 8, -1, 1'b1, 1'b1);
    chk("hold empty request", 10'h001, tx_irq);
    chk("line request", 10'h001, ls_irq);
    rd_chk("overrun", ADDR_LSR, 8'h63);
    chk("line request cleared", 10'h000, ls_irq);
    rd_chk("overrun cleared", ADDR_LSR, 8'h61);
    rd_chk("overwritten data", ADDR_DATA, 8'h22);
    wr(ADDR_LFC, 8'h1B);
    partner.send(8'h0F, 8, 1, 1'b1, 1'b1);
    rd_chk("parity error", ADDR_LSR, 8'h65);
    rd_chk("parity data", ADDR_DATA, 8'h0F);
    wr(ADDR_LFC, 8'h03);
    wr(ADDR_FIFO_CTRL, 8'h01);
    partner.send(8'h5A, 8, -1, 1'b0, 1'b1);
    partner.send(8'hC3, 8, -1, 1'b1, 1'b0);
    rd_chk("framing at head", ADDR_LSR, 8'hE9);
    rd_chk("framed data", ADDR_DATA, 8'h5A);
    rd_chk("clean head", ADDR_LSR, 8'h61, 8'h7F);
    rd_chk("resync data", ADDR_DATA, 8'hC3);
    rd_chk("fifo drained", ADDR_LSR, 8'h60);
    for (int i = 0; i < 24; i++)
      partner.put_bit(1'b0);
    partner.put_bit(1'b1);
    partner.put_bit(1'b1);
    rd_chk("break", ADDR_LSR, 8'hF9);
    rd_chk("break char", ADDR_DATA, 8'h00);
    rd_chk("one break char", ADDR_LSR, 8'h60, 8'h7F);
    for (int i = 0; i < 17; i++)
      partner.send(8'h30 + i[7:0], 8, -1, 1'b1, 1'b1);
    rd_chk("fifo overrun", ADDR_LSR, 8'h63);
    for (int i = 0; i < 16; i++)
      rd_chk("fifo data", ADDR_DATA, 8'h30 + i[7:0]);
    rd_chk("fifo empty", ADDR_LSR, 8'h60);
    test_done();
  end
endmodule // uart_line_format_and_status_tb_top

`default_nettype wire
